// >>> rtl/flow_controlled_async_serial.sv
/*
  Asynchronous serial transmitter and receiver with a flow-control pin,
  match hunting, array fill, inter-byte gap and send timeout.
  Assumes a plain register port with read data one cycle after the
  strobe, and pins synchronous to i_clk.
*/
// Strobed register access and the register offsets were decided locally.
`include "fcs_regs.svh"

module flow_controlled_async_serial #(
  parameter int DEPTH = 16,
  parameter int CYC_PER_US = `FCS_TICK_US * `FCS_CLK_MHZ
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Interrupt
  output logic o_irq,
  // Serial data pins
  input wire logic i_rx,
  output logic o_tx,
  output logic o_tx_oe,
  // Flow-control pin
  input wire logic i_flow,
  output logic o_flow,
  output logic o_flow_oe
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------
  // Microsecond tick
  // ----------------------------------------------------------
  logic [15:0] div_q;
  logic tick_q;
  wire div_end = (div_q == 16'(CYC_PER_US - 1));

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_end ? '0 : 16'(div_q + 16'h1);
      tick_q <= div_end;
    end
  end

  // ----------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------
  fcs_pkg::line_fmt_t fmt_q;
  fcs_pkg::tx_state_t tx_st_q;
  fcs_pkg::tx_item_t item_q;
  logic [15:0] pace_q, tmo_q, wcnt_q;
  logic [31:0] match_q;
  logic [3:0] mask_q, sts_q;
  logic [2:0] mlen_q, mi_q;
  logic flow_en_q, pace_en_q, tmo_en_q, match_en_q;
  logic [7:0] rxdata_q, k_q, len_w, ch_w;
  logic [AW:0] rx_cnt_q, lim_q;
  logic rx_busy_q, arr_mode_q, rx_drv_q, tx_used_q;
  logic [7:0] arr_q [DEPTH];

  wire wr_fmt = i_wr && (i_addr == `FCS_OFS_FMT);
  wire wr_pace = i_wr && (i_addr == `FCS_OFS_PACE);
  wire wr_tmo = i_wr && (i_addr == `FCS_OFS_TMO);
  wire wr_ctrl = i_wr && (i_addr == `FCS_OFS_CTRL);
  wire wr_match = i_wr && (i_addr == `FCS_OFS_MATCH);
  wire wr_item = i_wr && (i_addr == `FCS_OFS_ITEM);
  wire wr_rxcmd = i_wr && (i_addr == `FCS_OFS_RXCMD);
  wire wr_mask = i_wr && (i_addr == `FCS_OFS_MASK);
  wire rd_sts = i_rd && (i_addr == `FCS_OFS_STATUS);
  wire arr_hit = (i_addr >= `FCS_OFS_ARR) &&
                 (i_addr < 8'(`FCS_OFS_ARR + 4 * DEPTH));
  wire [AW-1:0] arr_idx = AW'((i_addr - `FCS_OFS_ARR) >> 2);

  // Timeout only exists with a flow pin; if both are asked, gap is dropped
  wire tmo_on = flow_en_q && tmo_en_q;
  wire pace_on = pace_en_q && !tmo_on;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      fmt_q <= `FCS_FMT_RST;
      pace_q <= `FCS_PACE_RST;
      tmo_q <= `FCS_TMO_RST;
      match_q <= `FCS_MATCH_RST;
      mask_q <= `FCS_MASK_RST;
      {flow_en_q, pace_en_q, tmo_en_q, match_en_q} <= 4'h0;
      mlen_q <= 3'h0;
    end else begin
      if (wr_fmt) fmt_q <= i_wdata[15:0];
      if (wr_pace) pace_q <= i_wdata[15:0];
      if (wr_tmo) tmo_q <= i_wdata[15:0];
      if (wr_match) match_q <= i_wdata;
      if (wr_mask) mask_q <= i_wdata[3:0];
      if (wr_ctrl) begin
        flow_en_q <= i_wdata[`FCS_CTRL_FLOW];
        pace_en_q <= i_wdata[`FCS_CTRL_PACE];
        tmo_en_q <= i_wdata[`FCS_CTRL_TMO];
        match_en_q <= i_wdata[`FCS_CTRL_MATCH];
        mlen_q <= i_wdata[`FCS_CTRL_MLEN +: 3];
      end
    end
  end

  // ----------------------------------------------------------
  // Transmit item expansion
  // ----------------------------------------------------------
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? 8'(8'h30 + n) : 8'(8'h37 + n);
  endfunction

  wire [7:0] v = item_q.value;

  always_comb begin
    len_w = 8'h01;
    ch_w = v;
    case (item_q.kind)
      fcs_pkg::K_REPEAT: len_w = item_q.count;
      fcs_pkg::K_DEC: begin
        len_w = 8'h03;
        ch_w = 8'(8'h30 + ((k_q == 8'h0) ? v / 8'd100 :
               (k_q == 8'h1) ? (v / 8'd10) % 8'd10 : v % 8'd10));
      end
      fcs_pkg::K_HEX: begin
        len_w = 8'h02;
        ch_w = hex_char((k_q == 8'h0) ? v[7:4] : v[3:0]);
      end
      fcs_pkg::K_BIN: begin
        len_w = 8'h08;
        ch_w = {7'h18, v[3'h7 - k_q[2:0]]};
      end
      fcs_pkg::K_ARRAY: begin
        len_w = item_q.count;
        ch_w = arr_q[k_q[AW-1:0]];
      end
      default: ch_w = v;
    endcase
  end

  // ----------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------
  logic tx_start_q, tx_busy, tx_line;
  logic [15:0] gcnt_q;
  wire perm = !flow_en_q || (i_flow == fmt_q.invert);
  wire in_flow = (tx_st_q == fcs_pkg::TX_FLOW);
  wire item_end = in_flow && (k_q == len_w);
  wire ev_tmo = in_flow && !item_end && !perm && tmo_on && tick_q &&
                (wcnt_q == tmo_q);
  wire tx_act = (tx_st_q != fcs_pkg::TX_IDLE);
  wire byte_end = (tx_st_q == fcs_pkg::TX_SEND) && !tx_busy &&
                  !tx_start_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      tx_st_q <= fcs_pkg::TX_IDLE;
      item_q <= '0;
      k_q <= '0;
      wcnt_q <= '0;
      gcnt_q <= '0;
      tx_start_q <= 1'b0;
      tx_used_q <= 1'b0;
    end else begin
      tx_start_q <= 1'b0;
      case (tx_st_q)
        fcs_pkg::TX_IDLE: begin
          if (wr_item) begin
            item_q <= fcs_pkg::tx_item_t'(i_wdata[18:0]);
            k_q <= '0;
            wcnt_q <= '0;
            tx_used_q <= 1'b1;
            tx_st_q <= fcs_pkg::TX_FLOW;
          end
        end
        fcs_pkg::TX_FLOW: begin
          if (item_end || ev_tmo) begin
            tx_st_q <= fcs_pkg::TX_IDLE;
          end else if (perm) begin
            tx_start_q <= 1'b1;
            tx_st_q <= fcs_pkg::TX_SEND;
          end else if (tmo_on && tick_q) begin
            wcnt_q <= 16'(wcnt_q + 16'h1);
          end
        end
        fcs_pkg::TX_SEND: begin
          if (byte_end) begin
            k_q <= 8'(k_q + 8'h1);
            wcnt_q <= '0;
            gcnt_q <= '0;
            // No gap after the last character of an item
            tx_st_q <= (pace_on && (8'(k_q + 8'h1) != len_w)) ?
                       fcs_pkg::TX_GAP : fcs_pkg::TX_FLOW;
          end
        end
        fcs_pkg::TX_GAP: begin
          if (gcnt_q == pace_q) tx_st_q <= fcs_pkg::TX_FLOW;
          else if (tick_q) gcnt_q <= 16'(gcnt_q + 16'h1);
        end
        default: tx_st_q <= fcs_pkg::TX_IDLE;
      endcase
    end
  end

  fcs_tx u_tx (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_tick(tick_q),
    .i_fmt(fmt_q),
    .i_start(tx_start_q),
    .i_data(ch_w),
    .o_busy(tx_busy),
    .o_line(tx_line)
  );

  // ----------------------------------------------------------
  // Receive control
  // ----------------------------------------------------------
  logic rx_valid, rx_perr;
  logic [7:0] rx_byte;
  wire match_done = !match_en_q || (mi_q == mlen_q);
  wire got = rx_busy_q && rx_valid && !rx_perr;
  wire store = got && match_done;
  wire ev_perr = rx_busy_q && rx_valid && rx_perr;
  wire ev_rxdone = store &&
                   (!arr_mode_q || ((AW+1)'(rx_cnt_q + 1'b1) == lim_q));
  wire [4:0] req_len = i_wdata[`FCS_RXCMD_LEN +: 5];

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rx_busy_q <= 1'b0;
      arr_mode_q <= 1'b0;
      rx_cnt_q <= '0;
      lim_q <= '0;
      mi_q <= '0;
      rxdata_q <= '0;
      rx_drv_q <= 1'b0;
      for (int i = 0; i < DEPTH; i++) arr_q[i] <= 8'h00;
    end else begin
      if (wr_item && !tx_act) rx_drv_q <= 1'b0;
      if (wr_rxcmd) begin
        rx_busy_q <= i_wdata[`FCS_RXCMD_START];
        arr_mode_q <= i_wdata[`FCS_RXCMD_ARR];
        rx_cnt_q <= '0;
        mi_q <= '0;
        rx_drv_q <= 1'b1;
        // A zero or oversized length fills the whole array
        lim_q <= ((req_len == 5'h0) || (32'(req_len) > DEPTH)) ?
                 (AW+1)'(DEPTH) : (AW+1)'(req_len);
      end else begin
        if (ev_perr || ev_rxdone) rx_busy_q <= 1'b0;
        if (got && !match_done) begin
          // Restart hunting, but a mismatch may itself open the sequence
          mi_q <= (rx_byte == match_q[8*mi_q[1:0] +: 8]) ?
                  3'(mi_q + 3'h1) :
                  ((rx_byte == match_q[7:0]) ? 3'h1 : 3'h0);
        end
        if (store && arr_mode_q) begin
          arr_q[rx_cnt_q[AW-1:0]] <= rx_byte;
          rx_cnt_q <= (AW+1)'(rx_cnt_q + 1'b1);
        end
        if (store && !arr_mode_q) rxdata_q <= rx_byte;
      end
    end
  end

  fcs_rx u_rx (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_tick(tick_q),
    .i_fmt(fmt_q),
    .i_en(rx_busy_q),
    .i_line(i_rx ^ fmt_q.invert),
    .o_valid(rx_valid),
    .o_data(rx_byte),
    .o_perr(rx_perr)
  );

  // ----------------------------------------------------------
  // Status, interrupt, read data and pins
  // ----------------------------------------------------------
  wire [3:0] ev = {ev_perr, ev_rxdone, ev_tmo, item_end};
  wire [3:0] sts_d = (rd_sts ? 4'h0 : sts_q) | ev;
  wire [31:0] state_w = {16'h0, 3'h0, 5'(rx_cnt_q), 5'h0,
                         in_flow, rx_busy_q, tx_act};
  wire [31:0] rsel =
    (i_addr == `FCS_OFS_FMT) ? {16'h0, fmt_q} :
    (i_addr == `FCS_OFS_PACE) ? {16'h0, pace_q} :
    (i_addr == `FCS_OFS_TMO) ? {16'h0, tmo_q} :
    (i_addr == `FCS_OFS_CTRL) ? {25'h0, mlen_q, match_en_q, tmo_en_q,
                                 pace_en_q, flow_en_q} :
    (i_addr == `FCS_OFS_MATCH) ? match_q :
    (i_addr == `FCS_OFS_STATE) ? state_w :
    (i_addr == `FCS_OFS_RXDATA) ? {24'h0, rxdata_q} :
    (i_addr == `FCS_OFS_STATUS) ? {28'h0, sts_q} :
    (i_addr == `FCS_OFS_MASK) ? {28'h0, mask_q} :
    arr_hit ? {24'h0, arr_q[arr_idx]} : 32'h0;
  // Open drain drives only the space level and floats for mark
  wire tx_oe_d = fmt_q.open_drain ? (tx_act && !tx_line) :
                 (tx_act || tx_used_q);
  wire flow_oe_d = flow_en_q && rx_drv_q && !tx_act;
  wire flow_d = rx_busy_q ? fmt_q.invert : !fmt_q.invert;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sts_q <= 4'h0;
      o_irq <= 1'b0;
      o_rdata <= 32'h0;
      o_tx <= 1'b0;
      o_tx_oe <= 1'b0;
      o_flow <= 1'b0;
      o_flow_oe <= 1'b0;
    end else begin
      sts_q <= sts_d;
      o_irq <= |(sts_d & mask_q);
      o_rdata <= i_rd ? rsel : 32'h0;
      o_tx <= tx_line ^ fmt_q.invert;
      o_tx_oe <= tx_oe_d;
      o_flow <= flow_d;
      o_flow_oe <= flow_oe_d;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  property p_tx_drive;
    @(posedge i_clk) disable iff (!i_rst_b)
    (tx_st_q == fcs_pkg::TX_SEND) && !fmt_q.open_drain |=> o_tx_oe;
  endproperty
  a_tx_drive: assert property (p_tx_drive)
    else $error("tx pin not driven while sending");

  property p_od_idle;
    @(posedge i_clk) disable iff (!i_rst_b)
    !tx_act && fmt_q.open_drain |=> !o_tx_oe;
  endproperty
  a_od_idle: assert property (p_od_idle)
    else $error("open drain pin driven while idle");

  property p_flow_stop;
    @(posedge i_clk) disable iff (!i_rst_b)
    flow_oe_d && !rx_busy_q |=> o_flow_oe && (o_flow != fmt_q.invert);
  endproperty
  a_flow_stop: assert property (p_flow_stop)
    else $error("flow pin not at stop level");

  property p_no_tmo;
    @(posedge i_clk) disable iff (!i_rst_b)
    in_flow && !flow_en_q |-> !ev_tmo;
  endproperty
  a_no_tmo: assert property (p_no_tmo)
    else $error("timeout without flow pin");

  property p_gap_excl;
    @(posedge i_clk) disable iff (!i_rst_b)
    (tx_st_q == fcs_pkg::TX_SEND) ##1 (tx_st_q == fcs_pkg::TX_GAP)
      |-> $past(pace_on);
  endproperty
  a_gap_excl: assert property (p_gap_excl)
    else $error("gap taken while timeout active");

  property p_tmo_exit;
    @(posedge i_clk) disable iff (!i_rst_b)
    ev_tmo |=> !tx_act && sts_q[`FCS_STS_TMO] && !tx_busy;
  endproperty
  a_tmo_exit: assert property (p_tmo_exit)
    else $error("timeout did not abandon sending");

  property p_fill_lim;
    @(posedge i_clk) disable iff (!i_rst_b)
    arr_mode_q |-> rx_cnt_q <= lim_q;
  endproperty
  a_fill_lim: assert property (p_fill_lim)
    else $error("array fill passed its limit");

  property p_fill_order;
    @(posedge i_clk) disable iff (!i_rst_b)
    store && arr_mode_q && !wr_rxcmd
      |=> arr_q[$past(rx_cnt_q[AW-1:0])] == $past(rx_byte);
  endproperty
  a_fill_order: assert property (p_fill_order)
    else $error("array element out of order");

  property p_hunt;
    @(posedge i_clk) disable iff (!i_rst_b)
    got && !match_done && !wr_rxcmd
      |=> (rx_cnt_q == $past(rx_cnt_q)) && rx_busy_q;
  endproperty
  a_hunt: assert property (p_hunt)
    else $error("character kept during hunt");

  property p_perr;
    @(posedge i_clk) disable iff (!i_rst_b)
    ev_perr && !wr_rxcmd |=> !rx_busy_q && sts_q[`FCS_STS_PERR];
  endproperty
  a_perr: assert property (p_perr)
    else $error("parity error not reported");

  c_tx_item: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    item_end);
  c_tmo: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    ev_tmo);
  c_fill: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    ev_rxdone && arr_mode_q);
endmodule // flow_controlled_async_serial

// >>> rtl/fcs_regs.svh
/*
  Register offsets, field positions, reset values and timing counts
  of the flow-controlled serial block.
  Assumes a byte-addressed register port with 32-bit data.
*/
// Functional notes
// - Discard characters until match sequence seen.
// - Array fill stores characters in arrival order.
// - Array fill stops after n characters.
// - Transmit pin driven during transmission; in open drain only for space bits.
// - Driver bit picks pin state after sending.
// - Transmitter samples flow pin as input.
// - Send timeout only with flow control.
// - Line-format word is a 16-bit value.
// - Programmable idle gap between sent bytes.
// - Gap and timeout never both active.
// - Abandon sending when permission times out.
// - Transmit items in any order and kind.
// - No receive buffer; idle characters lost.
// - Receiver drives go or stop on flow pin.
// - Format bits: period, 7E, inverted polarity.
// - Even parity generated and checked.
// - Open-drain option drives one level only.
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

// ----------------------------------------------------------
// Timing
// ----------------------------------------------------------
`define FCS_CLK_MHZ 200
`define FCS_TICK_US 1
`define FCS_PERIOD_BIAS 13'd20
`define FCS_FRAME_BITS 4'd10

// ----------------------------------------------------------
// Register offsets
// ----------------------------------------------------------
`define FCS_OFS_FMT 8'h00
`define FCS_OFS_PACE 8'h04
`define FCS_OFS_TMO 8'h08
`define FCS_OFS_CTRL 8'h0c
`define FCS_OFS_MATCH 8'h10
`define FCS_OFS_ITEM 8'h14
`define FCS_OFS_RXCMD 8'h18
`define FCS_OFS_STATE 8'h1c
`define FCS_OFS_RXDATA 8'h20
`define FCS_OFS_STATUS 8'h24
`define FCS_OFS_MASK 8'h28
`define FCS_OFS_ARR 8'h40

// ----------------------------------------------------------
// Fields
// ----------------------------------------------------------
`define FCS_CTRL_FLOW 0
`define FCS_CTRL_PACE 1
`define FCS_CTRL_TMO 2
`define FCS_CTRL_MATCH 3
`define FCS_CTRL_MLEN 4
`define FCS_RXCMD_START 0
`define FCS_RXCMD_ARR 1
`define FCS_RXCMD_LEN 8
`define FCS_STS_TXDONE 0
`define FCS_STS_TMO 1
`define FCS_STS_RXDONE 2
`define FCS_STS_PERR 3

// ----------------------------------------------------------
// Reset values
// ----------------------------------------------------------
`define FCS_FMT_RST 16'h0054
`define FCS_PACE_RST 16'h0000
`define FCS_TMO_RST 16'h0000
`define FCS_MATCH_RST 32'h0000_0000
`define FCS_MASK_RST 4'h0

`endif

// >>> rtl/fcs_pkg.sv
/*
  Types shared by the serial block files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcs_pkg;

  typedef struct packed {
    logic open_drain;
    logic invert;
    logic seven_even;
    logic spare;
    logic [11:0] period;
  } line_fmt_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FLOW = 2'b01,
    TX_SEND = 2'b11,
    TX_GAP = 2'b10
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b11,
    RX_STOP = 2'b10
  } rx_state_t;

  typedef enum logic [2:0] {
    K_BYTE = 3'h0,
    K_REPEAT = 3'h1,
    K_DEC = 3'h2,
    K_HEX = 3'h3,
    K_BIN = 3'h4,
    K_ARRAY = 3'h5
  } item_kind_t;

  typedef struct packed {
    item_kind_t kind;
    logic [7:0] count;
    logic [7:0] value;
  } tx_item_t;

endpackage

// >>> rtl/fcs_tx.sv
/*
  Character framer: shifts one ten-bit frame out on a logical line.
  Assumes a one-cycle microsecond tick and a stable format word.
*/
`include "fcs_regs.svh"

module fcs_tx (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Timing and format
  input wire logic i_tick,
  input wire fcs_pkg::line_fmt_t i_fmt,
  // Character in
  input wire logic i_start,
  input wire logic [7:0] i_data,
  // Line out, 1 is mark
  output logic o_busy,
  output logic o_line
);
  logic [9:0] frame_q;
  logic [12:0] tcnt_q;
  logic [3:0] n_q;
  logic busy_q;

  wire [12:0] per = {1'b0, i_fmt.period} + `FCS_PERIOD_BIAS;
  wire due = i_tick && (13'(tcnt_q + 13'h1) >= per);
  wire par = ^i_data[6:0];
  wire b7 = i_fmt.seven_even ? par : i_data[7];

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      frame_q <= 10'h3ff;
      tcnt_q <= '0;
      n_q <= '0;
      busy_q <= 1'b0;
    end else if (!busy_q) begin
      if (i_start) begin
        frame_q <= {1'b1, b7, i_data[6:0], 1'b0};
        tcnt_q <= '0;
        n_q <= '0;
        busy_q <= 1'b1;
      end
    end else if (i_tick) begin
      tcnt_q <= due ? '0 : 13'(tcnt_q + 13'h1);
      if (due) begin
        frame_q <= {1'b1, frame_q[9:1]};
        n_q <= 4'(n_q + 4'h1);
        busy_q <= (n_q != 4'(`FCS_FRAME_BITS - 4'h1));
      end
    end
  end

  assign o_busy = busy_q;
  assign o_line = frame_q[0];
endmodule // fcs_tx

// >>> rtl/fcs_rx.sv
/*
  Character sampler: finds a start bit, samples mid-bit, checks parity.
  Assumes the line is synchronous to the clock and already de-inverted.
*/
`include "fcs_regs.svh"

module fcs_rx (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Timing and format
  input wire logic i_tick,
  input wire fcs_pkg::line_fmt_t i_fmt,
  // Line in, 1 is mark
  input wire logic i_en,
  input wire logic i_line,
  // Character out
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_perr
);
  fcs_pkg::rx_state_t st_q;
  logic [12:0] tcnt_q;
  logic [7:0] bits_q;
  logic [2:0] n_q;

  wire [12:0] per = {1'b0, i_fmt.period} + `FCS_PERIOD_BIAS;
  wire [12:0] lim = (st_q == fcs_pkg::RX_START) ? {1'b0, per[12:1]} : per;
  wire due = i_tick && (13'(tcnt_q + 13'h1) >= lim);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_q <= fcs_pkg::RX_IDLE;
      tcnt_q <= '0;
      bits_q <= '0;
      n_q <= '0;
      o_valid <= 1'b0;
      o_data <= '0;
      o_perr <= 1'b0;
    end else begin
      o_valid <= 1'b0;
      o_perr <= 1'b0;
      if (i_tick) begin
        tcnt_q <= due ? '0 : 13'(tcnt_q + 13'h1);
      end
      if (!i_en) begin
        // Disabled: whatever is on the line is dropped
        st_q <= fcs_pkg::RX_IDLE;
      end else begin
        case (st_q)
          fcs_pkg::RX_IDLE: begin
            tcnt_q <= '0;
            n_q <= '0;
            if (!i_line) st_q <= fcs_pkg::RX_START;
          end
          fcs_pkg::RX_START: begin
            // A glitch shorter than half a bit is not a start
            if (due) st_q <= i_line ? fcs_pkg::RX_IDLE : fcs_pkg::RX_BITS;
          end
          fcs_pkg::RX_BITS: begin
            if (due) begin
              bits_q <= {i_line, bits_q[7:1]};
              n_q <= 3'(n_q + 3'h1);
              if (n_q == 3'h7) st_q <= fcs_pkg::RX_STOP;
            end
          end
          fcs_pkg::RX_STOP: begin
            if (due) begin
              st_q <= fcs_pkg::RX_IDLE;
              o_valid <= 1'b1;
              o_data <= i_fmt.seven_even ? {1'b0, bits_q[6:0]} : bits_q;
              o_perr <= i_fmt.seven_even && (^bits_q);
            end
          end
          default: st_q <= fcs_pkg::RX_IDLE;
        endcase
      end
    end
  end
endmodule // fcs_rx

// >>> tb/fcs_partner.sv
/*
  Far serial node: decodes frames from the block, sends frames to it
  and drives the flow pin. Assumes non-inverted 8-bit frames.
*/
module fcs_partner #(
  parameter int BIT_CYC = 80
) (
  // Clock
  input wire logic i_clk,
  // Line from the block
  input wire logic i_line,
  // Line to the block, flow pin drive
  output logic o_line,
  output logic o_flow,
  output logic o_flow_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  initial begin
    o_line = 1'b1;
    o_flow = 1'b1;
    o_flow_oe = 1'b0;
  end
  // Parity is not checked here, so 7E frames come back raw
  always begin
    @(posedge i_clk iff i_line === 1'b0);
    repeat (BIT_CYC / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge i_clk);
      sh[i] = i_line;
    end
    repeat (BIT_CYC) @(posedge i_clk);
    if (i_line === 1'b1) got_q.push_back(sh);
  end
  task automatic send(input logic [7:0] b);
    o_line <= 1'b0;
    repeat (BIT_CYC) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      o_line <= b[i];
      repeat (BIT_CYC) @(posedge i_clk);
    end
    o_line <= 1'b1;
    repeat (BIT_CYC) @(posedge i_clk);
  endtask
  task automatic flow(input logic oe, input logic lvl);
    // Change the pin only just after an edge
    @(posedge i_clk);
    o_flow_oe <= oe;
    o_flow <= lvl;
  endtask
endmodule // fcs_partner

// >>> tb/tb.sv
/*
  Bench for the serial block, one task per scenario.
  Assumes the far node model and four cycles per microsecond.
*/
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_b, i_wr, i_rd;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic [31:0] o_rdata, d;
  logic [7:0] c;
  logic o_irq, o_tx, o_tx_oe, o_flow, o_flow_oe;
  logic p_line, p_flow, p_flow_oe, tx_pin, flow_pin;
  int errors = 0;
  int compares = 0;
  // Pull-up on data, pull-down on flow
  assign tx_pin = o_tx_oe ? o_tx : 1'b1;
  assign flow_pin = o_flow_oe ? o_flow : (p_flow_oe ? p_flow : 1'b0);
  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;
  flow_controlled_async_serial #(.DEPTH(16), .CYC_PER_US(4))
    i_flow_controlled_async_serial (.i_clk, .i_rst_b, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_irq, .i_rx(p_line), .o_tx, .o_tx_oe,
    .i_flow(flow_pin), .o_flow, .o_flow_oe);
  fcs_partner #(.BIT_CYC(80)) i_fcs_partner (.i_clk, .i_line(tx_pin),
    .o_line(p_line), .o_flow(p_flow), .o_flow_oe(p_flow_oe));
  // ----------------
  // Bus tasks
  // ----------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 3000; k++) begin
      rd(8'h1c);
      if (d[1:0] === 2'b00) return;
    end
    errors++;
    summarize();
  endtask
  task automatic pop_chk(input logic [7:0] e);
    c = i_fcs_partner.got_q.pop_front();
    `CHK("char", e, c)
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs();
    rd(8'h00);
    `CHK("fmt rst", 32'h0000_0054, d)
    wr(8'h00, 32'h0000_ffff);
    rd(8'h00);
    `CHK("fmt", 32'h0000_ffff, d)
    rd(8'h3c);
    `CHK("unmapped", 32'h0000_0000, d)
    wr(8'h00, 32'h0000_0000);
  endtask
  // Timeout enabled without flow pin: must not fire even at zero
  task automatic t_tx();
    wr(8'h0c, 32'h0000_0004);
    wr(8'h14, 32'h0000_005a);
    repeat (40) @(posedge i_clk);
    `CHK("tx oe", 1'b1, o_tx_oe)
    wait_idle();
    pop_chk(8'h5a);
    `CHK("irq masked", 1'b0, o_irq)
    wr(8'h28, 32'h0000_000f);
    repeat (2) @(posedge i_clk);
    `CHK("irq", 1'b1, o_irq)
    rd(8'h24);
    `CHK("status", 32'h0000_0001, d)
    repeat (2) @(posedge i_clk);
    `CHK("irq clr", 1'b0, o_irq)
    `CHK("tx idle", 2'b11, {o_tx_oe, o_tx})
  endtask
  task automatic t_od();
    wr(8'h00, 32'h0000_a000);
    wr(8'h14, 32'h0001_021a);
    wait_idle();
    pop_chk(8'h9a);
    pop_chk(8'h9a);
    `CHK("od idle", 1'b0, o_tx_oe)
    rd(8'h24);
    wr(8'h00, 32'h0000_0000);
  endtask
  task automatic t_flow();
    wr(8'h0c, 32'h0000_0005);
    wr(8'h08, 32'h0000_0005);
    i_fcs_partner.flow(1'b1, 1'b1);
    wr(8'h14, 32'h0000_0033);
    repeat (3) @(posedge i_clk);
    `CHK("flow in", 1'b0, o_flow_oe)
    wait_idle();
    rd(8'h24);
    `CHK("tmo", 1'b1, d[1])
    `CHK("none", 0, i_fcs_partner.got_q.size())
    i_fcs_partner.flow(1'b1, 1'b0);
    wr(8'h14, 32'h0000_0033);
    wait_idle();
    pop_chk(8'h33);
    i_fcs_partner.flow(1'b0, 1'b0);
  endtask
  // Fourth character lands after the count is reached
  task automatic t_arr();
    wr(8'h18, 32'h0000_0303);
    repeat (2) @(posedge i_clk);
    `CHK("go", 2'b10, {o_flow_oe, o_flow})
    for (logic [7:0] b = 8'h61; b < 8'h65; b++) i_fcs_partner.send(b);
    `CHK("stop", 2'b11, {o_flow_oe, o_flow})
    for (int i = 0; i < 5; i++) begin
      rd(8'h40 + 8'(4 * i));
      `CHK("elem", (i < 3) ? 32'h61 + i : 32'h0, d)
    end
  endtask
  task automatic t_match();
    wr(8'h0c, 32'h0000_0029);
    wr(8'h10, 32'h0000_4241);
    rd(8'h24);
    wr(8'h18, 32'h0000_0001);
    i_fcs_partner.send(8'h41);
    i_fcs_partner.send(8'h41);
    i_fcs_partner.send(8'h42);
    i_fcs_partner.send(8'h43);
    wait_idle();
    rd(8'h20);
    `CHK("match", 32'h0000_0043, d)
    rd(8'h24);
    `CHK("rx done", 1'b1, d[2])
  endtask
  // Array item with a gap, then decimal and hex where timeout drops it
  task automatic t_pace();
    realtime t0;
    wr(8'h04, 32'h0000_0064);
    wr(8'h0c, 32'h0000_0002);
    t0 = $realtime;
    wr(8'h14, 32'h0005_0200);
    wait_idle();
    pop_chk(8'h61);
    pop_chk(8'h62);
    `CHK("gap", 1'b1, ($realtime - t0) > 9500)
    wr(8'h0c, 32'h0000_0007);
    t0 = $realtime;
    wr(8'h14, 32'h0002_007b);
    wait_idle();
    pop_chk(8'h31);
    pop_chk(8'h32);
    pop_chk(8'h33);
    `CHK("no gap", 1'b1, ($realtime - t0) < 14000)
    wr(8'h14, 32'h0003_004e);
    wait_idle();
    pop_chk(8'h34);
    pop_chk(8'h45);
  endtask
  // Odd frame in 7E aborts the receive; even frame comes back 7-bit
  task automatic t_perr();
    wr(8'h0c, 32'h0000_0000);
    wr(8'h00, 32'h0000_2000);
    rd(8'h24);
    wr(8'h18, 32'h0000_0001);
    i_fcs_partner.send(8'h01);
    wait_idle();
    rd(8'h24);
    `CHK("perr", 4'h8, d[3:0])
    wr(8'h18, 32'h0000_0001);
    i_fcs_partner.send(8'h81);
    wait_idle();
    rd(8'h20);
    `CHK("7e data", 32'h0000_0001, d)
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_tx();
    t_od();
    t_flow();
    t_arr();
    t_match();
    t_pace();
    t_perr();
    summarize();
  end
endmodule // tb
